// File: shared/wave_pkg.sv
// Purpose: constants and types for the two-channel waveform converter sequencer
// Assumes: core_clk at 50 MHz; timing counters advance on a derived 40 MHz tick
// Notes: stop mode code 2'h3 behaves as an immediate stop
//
// Contract
// RL1: two independent output channels, each carrying a 12-bit code.
// RL2: bipolar uses offset binary, 12'h800 is zero, step is ref/2048.
// RL3: unipolar uses straight binary, code times ref/4096, zero code gives zero.
// RL4: each channel picks its own mode, polarity and reference source.
// RL5: software mode: a write of a code updates that converter directly.
// RL6: timed output starts only on trigger once samples are buffered.
// RL7: 24-bit interval counter spaces updates in master_tick_clock periods.
// RL8: 24-bit updates per waveform; 24-bit waveform iteration count.
// RL9: one write strobe pulse per update applies the new sample.
// RL10: software keeps the interval at 40 or more, at most 1 MHz updates.
// RL11: post-trigger starts output at once, ignoring the first delay.
// RL12: delay-trigger: 16-bit first delay counts down, generation starts at zero.
// RL13: first delay clocks on master_tick_clock tick or on update-period tick.
// RL14: with re-trigger, each trigger starts one generation; busy triggers ignored.
// RL15: waveform fitting the sample store is replayed; otherwise refilled from host.
// RL16: sample store holds 2k samples, or 512 in the smaller variant.
// RL17: infinite iteration uses the iteration count only for third stop mode.
// RL18: 16-bit second delay runs between waveforms; next starts at zero.
// RL19: first stop mode halts output immediately on the stop command.
// RL20: second stop mode finishes the current waveform before halting.
// RL21: third stop mode halts when waveforms done is multiple of iteration count.
// RL22: the timing counters run from a 40 MHz master_tick_clock.
// RL23: finite iteration ends after the programmed waveforms and updates.
// RL24: interval reloads every update; update count reloads each waveform.

package wave_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int NUM_CH = 2;
	localparam int CODE_W = 12;
	localparam int CNT_W = 24;
	localparam int DLY_W = 16;
	localparam int MEM_AW = 11;
	localparam int FIFO_DEPTH = 4;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int MASTER_TICK_CLOCK_HZ = 40_000_000;
	localparam int RATE_UNIT_HZ = 1_000_000;
	localparam int MAX_UPDATE_HZ = 1_000_000;
	localparam int MIN_INTERVAL = MASTER_TICK_CLOCK_HZ / MAX_UPDATE_HZ;
	localparam int ACC_W = 7;
	localparam logic [ACC_W-1:0] TICK_STEP = ACC_W'(MASTER_TICK_CLOCK_HZ / RATE_UNIT_HZ);
	localparam logic [ACC_W-1:0] TICK_WRAP = ACC_W'(CLK_HZ / RATE_UNIT_HZ);

	// ----------------------------------------
	// values
	// ----------------------------------------
	localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
	localparam logic [DLY_W-1:0] DLY_ONE = 16'h0001;
	localparam logic [DLY_W-1:0] DLY_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] STORE_LARGE = 24'h000800;
	localparam logic [CNT_W-1:0] STORE_SMALL = 24'h000200;
	localparam logic [MEM_AW-1:0] IDX_ONE = 11'h001;
	localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
	localparam logic [CODE_W-1:0] BIPOLAR_ZERO = 12'h800;
	localparam logic [CODE_W-1:0] UNIPOLAR_ZERO = 12'h000;

	// ----------------------------------------
	// encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		STOP_IMMEDIATE = 2'h0,
		STOP_WAVEFORM = 2'h1,
		STOP_ITERATION = 2'h2
	} stop_mode_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_DELAY1 = 4'h2,
		ST_RUN = 4'h4,
		ST_DELAY2 = 4'h8
	} seq_state_t;

endpackage

// File: logic/waveform_dac_sequencer.sv
// Purpose: sequencer for two converter channels, software and timed waveform modes
// Assumes: all inputs synchronous to core_clk; host feed is valid/ready
// Notes: sample store replay is combinational read of a local array
`timescale 1ns/10ps

// ----------------------------------------
// small elastic buffer on the host feed
// ----------------------------------------
module sample_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 4
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW:0] CNT_STEP = (AW+1)'(1);
	localparam logic [AW-1:0] PTR_STEP = AW'(1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic in_ready;
	} fifo_t;

	localparam fifo_t FIFO_RESET = '{mem: '0, wp: '0, rp: '0, cnt: '0, in_ready: 1'b1};

	fifo_t s;
	fifo_t next_s;
	logic push;
	logic pop;

	assign push = in_valid && s.in_ready;
	assign pop = (s.cnt != '0) && out_ready;
	assign in_ready = s.in_ready;
	assign out_valid = (s.cnt != '0);
	assign out_data = s.mem[s.rp];

	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wp] = in_data;
			next_s.wp = s.wp + PTR_STEP;
		end
		if (pop) begin
			next_s.rp = s.rp + PTR_STEP;
		end
		if (push && !pop) begin
			next_s.cnt = s.cnt + CNT_STEP;
		end else if (pop && !push) begin
			next_s.cnt = s.cnt - CNT_STEP;
		end
		// ready is a flop set from the next count, so it drops in the same cycle the buffer becomes full
		next_s.in_ready = (next_s.cnt != FULL);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= FIFO_RESET;
		end else begin
			s <= next_s;
		end
	end
endmodule

// ----------------------------------------
// top: channel outputs and timed sequencer
// ----------------------------------------
module waveform_dac_sequencer
	import wave_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [NUM_CH-1:0] chan_timed,
	input wire logic [NUM_CH-1:0] chan_bipolar,
	input wire logic [NUM_CH-1:0] chan_external_ref,
	input wire logic [NUM_CH-1:0] sw_write,
	input wire logic [NUM_CH-1:0][CODE_W-1:0] sw_code,
	input wire logic small_variant,
	input wire logic arm,
	input wire logic trigger,
	input wire logic delay_trigger_mode,
	input wire logic retrigger_enable,
	input wire logic delay1_on_update_tick,
	input wire logic infinite_iteration,
	input wire logic stop_cmd,
	input wire logic [1:0] stop_mode,
	input wire logic [CNT_W-1:0] update_interval_count,
	input wire logic [CNT_W-1:0] updates_per_waveform,
	input wire logic [CNT_W-1:0] waveform_iteration_count,
	input wire logic [DLY_W-1:0] first_delay_count,
	input wire logic [DLY_W-1:0] second_delay_count,
	input wire logic sample_valid,
	output logic sample_ready,
	input wire logic [CODE_W-1:0] sample_data,
	output logic [NUM_CH-1:0][CODE_W-1:0] dac_code,
	output logic [NUM_CH-1:0] converter_write_strobe,
	output logic [NUM_CH-1:0] bipolar_out,
	output logic [NUM_CH-1:0] external_output_reference,
	output logic busy,
	output logic stop_pending
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		seq_state_t st;
		logic [ACC_W-1:0] acc;
		logic tick;
		logic armed;
		logic pending;
		logic loaded;
		logic take;
		logic [CNT_W-1:0] ui;
		logic [CNT_W-1:0] uc;
		logic [CNT_W-1:0] iter;
		logic [DLY_W-1:0] dly;
		logic [MEM_AW-1:0] idx;
		logic [NUM_CH-1:0][CODE_W-1:0] code;
		logic [NUM_CH-1:0] strobe;
		logic [NUM_CH-1:0] bipolar;
		logic [NUM_CH-1:0] ext_ref;
		logic busy;
	} seq_t;

	localparam seq_t SEQ_RESET = '{
		st: ST_IDLE, acc: '0, tick: 1'b0, armed: 1'b0, pending: 1'b0, loaded: 1'b0,
		take: 1'b0, ui: '0, uc: '0, iter: '0, dly: '0, idx: '0,
		code: {NUM_CH{CODE_RESET}}, strobe: '0, bipolar: '0, ext_ref: '0, busy: 1'b0
	};

	seq_t s;
	seq_t next_s;

	// sample store for replay; no reset, contents only valid once loaded
	logic [CODE_W-1:0] store [0:(1<<MEM_AW)-1];

	logic fifo_valid;
	logic [CODE_W-1:0] fifo_data;
	logic [ACC_W:0] acc_sum;
	logic [CNT_W-1:0] iv_eff;
	logic [CNT_W-1:0] uc_eff;
	logic [CNT_W-1:0] ic_eff;
	logic [CNT_W-1:0] capacity;
	logic fits;
	logic replay;
	logic avail;
	logic ui_expire;
	logic update;
	logic last_update;
	logic wrap;
	logic [CODE_W-1:0] sample;
	logic store_we;
	logic [NUM_CH-1:0] ch_load;
	logic [NUM_CH-1:0][CODE_W-1:0] ch_code_next;

	// ----------------------------------------
	// host feed buffer
	// ----------------------------------------
	sample_fifo #(
		.WIDTH(CODE_W),
		.DEPTH(FIFO_DEPTH)
	) feed (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.in_data(sample_data),
		.out_valid(fifo_valid),
		.out_ready(s.take),
		.out_data(fifo_data)
	);

	// ----------------------------------------
	// derived terms
	// ----------------------------------------
	// zero in a count field is taken as one so the counters never stall
	assign iv_eff = (update_interval_count == '0) ? CNT_ONE : update_interval_count;
	assign uc_eff = (updates_per_waveform == '0) ? CNT_ONE : updates_per_waveform;
	assign ic_eff = (waveform_iteration_count == '0) ? CNT_ONE : waveform_iteration_count;
	assign acc_sum = {1'b0, s.acc} + {1'b0, TICK_STEP};
	assign capacity = small_variant ? STORE_SMALL : STORE_LARGE; // [RL16]
	assign fits = (uc_eff <= capacity); // [RL15]
	assign replay = s.loaded && fits; // [RL15]
	// take blocks a second use of the same head word before the pop lands
	assign avail = replay || (fifo_valid && !s.take);
	assign ui_expire = s.tick && (s.ui <= CNT_ONE); // [RL7]
	// an immediate stop also cancels an update due in that cycle, so code and strobe stay paired
	assign update = (s.st == ST_RUN) && ui_expire && avail &&
		!(stop_cmd && (stop_mode != STOP_WAVEFORM) && (stop_mode != STOP_ITERATION)); // [RL19]
	assign last_update = update && (s.uc <= CNT_ONE);
	assign wrap = ((s.iter + CNT_ONE) >= ic_eff);
	assign sample = replay ? store[s.idx] : fifo_data; // [RL15]
	assign store_we = update && !replay && fits;

	always_ff @(posedge core_clk) begin
		if (store_we) begin
			store[s.idx] <= fifo_data;
		end
	end

	// ----------------------------------------
	// per-channel output selection
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : chan
			// each channel follows its own mode bit [RL4]
			assign ch_load[g] = chan_timed[g] ? update : sw_write[g]; // [RL5] [RL9]
			assign ch_code_next[g] = !ch_load[g] ? s.code[g] :
				(chan_timed[g] ? sample : sw_code[g]); // [RL1]
		end
	endgenerate

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		// fractional divider: 4 ticks in every 5 clocks gives 40 MHz [RL22]
		if (acc_sum >= {1'b0, TICK_WRAP}) begin
			next_s.acc = ACC_W'(acc_sum - {1'b0, TICK_WRAP});
			next_s.tick = 1'b1;
		end else begin
			next_s.acc = ACC_W'(acc_sum);
			next_s.tick = 1'b0;
		end
		next_s.code = ch_code_next;
		next_s.strobe = ch_load; // [RL9]
		// code passes unchanged; polarity decides offset or straight binary [RL2] [RL3]
		next_s.bipolar = chan_bipolar; // [RL2] [RL3]
		next_s.ext_ref = chan_external_ref; // [RL4]
		next_s.take = update && !replay; // [RL15]
		if (arm) begin
			next_s.armed = 1'b1;
			next_s.loaded = 1'b0;
		end

		unique case (s.st)
			ST_IDLE: begin
				next_s.pending = 1'b0;
				// start needs buffered samples or a loaded store [RL6]
				if (s.armed && trigger && (replay || fifo_valid)) begin
					next_s.armed = retrigger_enable; // [RL14]
					next_s.iter = '0;
					next_s.ui = iv_eff;
					if (delay_trigger_mode && (first_delay_count != DLY_ZERO)) begin
						next_s.st = ST_DELAY1; // [RL12]
						next_s.dly = first_delay_count;
					end else begin
						next_s.st = ST_RUN; // [RL11]
						next_s.uc = uc_eff; // [RL24]
						next_s.idx = '0;
					end
				end
			end
			ST_DELAY1: begin
				// both tick sources are handled by one counter [RL13]
				if (s.tick) begin
					if (ui_expire) begin
						next_s.ui = iv_eff; // [RL13]
					end else begin
						next_s.ui = s.ui - CNT_ONE;
					end
					// the run must open with a full interval, so its reload comes last
					if (!delay1_on_update_tick || ui_expire) begin
						if (s.dly <= DLY_ONE) begin
							next_s.st = ST_RUN; // [RL12]
							next_s.uc = uc_eff; // [RL24]
							next_s.idx = '0;
							next_s.ui = iv_eff;
						end else begin
							next_s.dly = s.dly - DLY_ONE; // [RL12]
						end
					end
				end
				// nothing has been output yet, so every stop mode ends here
				if (stop_cmd) begin
					next_s.st = ST_IDLE;
					next_s.armed = 1'b0;
				end
			end
			ST_RUN: begin
				if (s.tick) begin
					if (!ui_expire) begin
						next_s.ui = s.ui - CNT_ONE; // [RL7]
					end else if (update) begin
						next_s.ui = iv_eff; // [RL24]
					end
				end
				if (update) begin
					next_s.uc = s.uc - CNT_ONE; // [RL8]
					next_s.idx = s.idx + IDX_ONE;
				end
				if (stop_cmd && (stop_mode != STOP_WAVEFORM) && (stop_mode != STOP_ITERATION)) begin
					next_s.st = ST_IDLE; // [RL19]
					next_s.armed = 1'b0;
					next_s.take = 1'b0;
					next_s.strobe = ch_load & ~chan_timed;
				end else begin
					if (stop_cmd) begin
						next_s.pending = 1'b1;
					end
					if (last_update) begin
						next_s.loaded = s.loaded || fits; // [RL15]
						next_s.iter = wrap ? '0 : (s.iter + CNT_ONE); // [RL8]
						if ((!infinite_iteration && wrap) || // [RL23] [RL17]
							(next_s.pending && (stop_mode == STOP_WAVEFORM)) || // [RL20]
							(next_s.pending && (stop_mode == STOP_ITERATION) && wrap)) begin // [RL21]
							next_s.st = ST_IDLE;
							// a stop disarms; a natural end keeps re-trigger armed
							if (next_s.pending) begin
								next_s.armed = 1'b0;
							end
							next_s.pending = 1'b0;
						end else if (second_delay_count == DLY_ZERO) begin
							next_s.uc = uc_eff; // [RL24]
							next_s.idx = '0;
						end else begin
							next_s.st = ST_DELAY2; // [RL18]
							next_s.dly = second_delay_count;
							next_s.ui = iv_eff;
						end
					end
				end
			end
			ST_DELAY2: begin
				// second delay counts in update periods
				if (s.tick) begin
					if (ui_expire) begin
						next_s.ui = iv_eff;
						if (s.dly <= DLY_ONE) begin
							next_s.st = ST_RUN; // [RL18]
							next_s.uc = uc_eff; // [RL24]
							next_s.idx = '0;
						end else begin
							next_s.dly = s.dly - DLY_ONE; // [RL18]
						end
					end else begin
						next_s.ui = s.ui - CNT_ONE;
					end
				end
				// a waveform has just completed, so mode two may end here too
				if (stop_cmd || s.pending) begin
					if ((stop_mode != STOP_ITERATION) || (s.iter == '0)) begin
						next_s.st = ST_IDLE; // [RL19] [RL20] [RL21]
						next_s.pending = 1'b0;
						next_s.armed = 1'b0;
					end else begin
						next_s.pending = 1'b1;
					end
				end
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase
		next_s.busy = (next_s.st != ST_IDLE);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= SEQ_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign dac_code = s.code;
	assign converter_write_strobe = s.strobe;
	assign bipolar_out = s.bipolar;
	assign external_output_reference = s.ext_ref;
	assign busy = s.busy;
	assign stop_pending = s.pending;

endmodule

// File: testbench/waveform_dac_sequencer_monitor.sv
// Purpose: port checks for the waveform sequencer
// Assumes: one core_clk domain, rst_n async low
// Notes: timed checks look at the case where both channels are timed
`timescale 1ns/10ps

module waveform_dac_sequencer_monitor
	import wave_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [NUM_CH-1:0] chan_timed,
	input wire logic [NUM_CH-1:0] chan_bipolar,
	input wire logic [NUM_CH-1:0] chan_external_ref,
	input wire logic [NUM_CH-1:0] sw_write,
	input wire logic [NUM_CH-1:0][CODE_W-1:0] sw_code,
	input wire logic stop_cmd,
	input wire logic [1:0] stop_mode,
	input wire logic [NUM_CH-1:0][CODE_W-1:0] dac_code,
	input wire logic [NUM_CH-1:0] converter_write_strobe,
	input wire logic [NUM_CH-1:0] bipolar_out,
	input wire logic [NUM_CH-1:0] external_output_reference,
	input wire logic busy,
	input wire logic stop_pending
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_sw_update;
		sw_write[0] && !chan_timed[0] |=> converter_write_strobe[0] && dac_code[0] == $past(sw_code[0]);
	endproperty
	a_sw_update: assert property (p_sw_update) else $error("software load lost");
	property p_levels;
		1'b1 |=> bipolar_out == $past(chan_bipolar) && external_output_reference == $past(chan_external_ref);
	endproperty
	a_levels: assert property (p_levels) else $error("polarity or reference wrong");
	// codes 0 and 3 both stop at once
	property p_stop_now;
		busy && stop_cmd && stop_mode[0] == stop_mode[1] |-> ##[1:2] !busy [*3];
	endproperty
	a_stop_now: assert property (p_stop_now) else $error("immediate stop late");
	property p_pending_idle;
		!busy && !$past(busy) |-> !stop_pending;
	endproperty
	a_pending_idle: assert property (p_pending_idle) else $error("stale stop pending");
	property p_idle_quiet;
		!busy && !$past(busy) && !$past(busy, 2) && chan_timed == 2'h3 |-> converter_write_strobe == 2'h0;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("strobe while idle");
	property p_timed_pair;
		chan_timed == 2'h3 && $past(chan_timed) == 2'h3 |-> converter_write_strobe[0] == converter_write_strobe[1];
	endproperty
	a_timed_pair: assert property (p_timed_pair) else $error("timed strobes differ");
	property p_timed_code;
		chan_timed == 2'h3 && converter_write_strobe[0] |-> dac_code[0] == dac_code[1];
	endproperty
	a_timed_code: assert property (p_timed_code) else $error("timed codes differ");
	property p_code_hold;
		converter_write_strobe == 2'h0 |-> $stable(dac_code);
	endproperty
	a_code_hold: assert property (p_code_hold) else $error("code moved without strobe");

	c_sw: cover property (sw_write[0] && !chan_timed[0]);
	c_pend: cover property (busy && stop_pending);
	c_done: cover property ($fell(busy));
endmodule

bind waveform_dac_sequencer waveform_dac_sequencer_monitor i_waveform_dac_sequencer_monitor (
	.core_clk, .rst_n, .chan_timed, .chan_bipolar, .chan_external_ref, .sw_write, .sw_code,
	.stop_cmd, .stop_mode, .dac_code, .converter_write_strobe, .bipolar_out,
	.external_output_reference, .busy, .stop_pending
);

// File: testbench/host_feed_model.sv
// Purpose: host feed standing in for the DMA path into the sample buffer
// Assumes: a word is taken on an edge with valid and ready high
// Notes: an idle data bus shows the inverse of its last value
`timescale 1ns/10ps

module host_feed_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic stall,
	input wire logic sample_ready,
	output logic sample_valid,
	output logic [11:0] sample_data
);
	logic [11:0] words[$];
	logic taken;

	initial begin
		sample_valid = 1'b0;
		sample_data = 12'h000;
	end

	task load(input logic [11:0] word);
		words.push_back(word);
	endtask

	// offer held until taken; stall only delays the next offer
	always @(posedge core_clk) begin
		taken = sample_valid && sample_ready;
		#1;
		if (taken)
			words.delete(0);
		if (!rst_n || !sample_valid || taken) begin
			sample_valid = rst_n && !stall && words.size() > 0;
			sample_data = sample_valid ? words[0] : ~sample_data;
		end
	end
endmodule

// File: testbench/test_waveform_dac_sequencer.sv
// Purpose: self-checking bench for the waveform sequencer
// Assumes: channel 1 is always timed and observed
// Notes: intervals stay at 40 or more, watchdog at 50000 cycles
`timescale 1ns/10ps

module test_waveform_dac_sequencer;
	import wave_pkg::*;

	logic core_clk = 1'b0, rst_n = 1'b0, stall = 1'b0;
	logic [1:0] chan_timed = 2'h3, chan_bipolar = 2'h0, chan_external_ref = 2'h0, sw_write = 2'h0;
	logic [1:0][11:0] sw_code = '0;
	logic small_variant = 1'b0, arm = 1'b0, trigger = 1'b0, delay_trigger_mode = 1'b0;
	logic retrigger_enable = 1'b0, delay1_on_update_tick = 1'b0, infinite_iteration = 1'b0, stop_cmd = 1'b0;
	logic [1:0] stop_mode = 2'h0;
	logic [23:0] update_interval_count = 24'h000028, updates_per_waveform = 24'h000001;
	logic [23:0] waveform_iteration_count = 24'h000001;
	logic [15:0] first_delay_count = 16'h0000, second_delay_count = 16'h0000;
	logic sample_valid, sample_ready, busy, stop_pending;
	logic [11:0] sample_data;
	logic [1:0][11:0] dac_code;
	logic [1:0] converter_write_strobe, bipolar_out, external_output_reference;
	int seed = 32'hFBA0;
	int num_errors = 0, num_checks = 0, iv, k;
	logic [11:0] w[$];

	always #10 core_clk = ~core_clk;

	waveform_dac_sequencer i_waveform_dac_sequencer (.core_clk, .rst_n, .chan_timed, .chan_bipolar,
		.chan_external_ref, .sw_write, .sw_code, .small_variant, .arm, .trigger, .delay_trigger_mode,
		.retrigger_enable, .delay1_on_update_tick, .infinite_iteration, .stop_cmd, .stop_mode,
		.update_interval_count, .updates_per_waveform, .waveform_iteration_count, .first_delay_count,
		.second_delay_count, .sample_valid, .sample_ready, .sample_data, .dac_code,
		.converter_write_strobe, .bipolar_out, .external_output_reference, .busy, .stop_pending);
	host_feed_model i_host_feed_model (.core_clk, .rst_n, .stall, .sample_ready, .sample_valid, .sample_data);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task test_done();
		if (num_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task step();
		@(posedge core_clk);
		#1;
	endtask

	function automatic int expect_updates(input int n, it, sm, stop_at);
		int unit;
		if (stop_at == 0)
			return n * it;
		unit = (sm == 1) ? n : (sm == 2) ? n * it : 1;
		return (stop_at + unit - 1) / unit * unit;
	endfunction

	// one generation: load, arm, trigger, collect strobes of channel 1
	task automatic go(input int n, it, dm, onu, d1, d2, inf, sm, stop_at, rt, ld, stl);
		int cnt, gap, tk, j;
		bit hit;
		if (ld) begin
			w.delete();
			iv = 40 + ($random(seed) & 7);
			for (j = 0; j < n; j++) begin
				w.push_back(12'($random(seed)));
				i_host_feed_model.load(w[j]);
			end
		end
		update_interval_count = 24'(iv);
		updates_per_waveform = 24'(n);
		waveform_iteration_count = 24'(it);
		delay_trigger_mode = 1'(dm);
		delay1_on_update_tick = 1'(onu);
		first_delay_count = 16'(d1);
		second_delay_count = 16'(d2);
		infinite_iteration = 1'(inf);
		stop_mode = 2'(sm);
		chan_bipolar = 2'($random(seed));
		chan_external_ref = 2'($random(seed));
		small_variant = 1'($random(seed)); // every test waveform fits either store size
		arm = 1'(ld);
		step();
		arm = 1'b0;
		repeat (n + 4) step();
		if (n > FIFO_DEPTH)
			chk("feed full", sample_ready, 1'b0);
		trigger = 1'b1;
		cnt = 0;
		gap = 0;
		for (j = 0; j < 40000; j++) begin
			step();
			gap++;
			hit = converter_write_strobe[1] === 1'b1;
			if (hit) begin
				tk = (cnt == 0) ? iv + (dm ? (onu ? d1 * iv : d1) : 0) : (cnt % n == 0) ? iv * (d2 + 1) : iv;
				chk("spacing", gap >= tk * 5 / 4 - 2 && (stl || gap <= tk * 5 / 4 + 4), 1'b1);
				chk("sample", dac_code[1], w[cnt % n]);
				cnt++;
				gap = 0;
			end
			trigger = hit && cnt == 2 && rt;
			stop_cmd = hit && cnt == stop_at;
			sw_write = 2'($random(seed));
			sw_code = 24'($random(seed));
			stall = stl && ($random(seed) & 1);
			if (busy !== 1'b1 && gap > 4)
				break;
		end
		sw_write = 2'h0;
		stall = 1'b0;
		chk("updates", 24'(cnt), 24'(expect_updates(n, it, sm, stop_at)));
		chk("feed empty", sample_ready, 1'b1);
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		go(4, 2, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0);
		trigger = 1'b1;
		step();
		trigger = 1'b0;
		step();
		chk("no rearm", busy, 1'b0);
		go(3, 2, 1, 0, 1 + ($random(seed) & 255), 0, 0, 0, 0, 0, 1, 0);
		go(3, 1, 1, 1, 3, 0, 0, 0, 0, 0, 1, 0);
		chan_timed = 2'h2;
		go(4, 3, 0, 0, 0, 2, 0, 0, 0, 0, 1, 0);
		retrigger_enable = 1'b1;
		go(2, 2, 0, 0, 0, 0, 0, 0, 0, 1, 1, 0);
		go(2, 2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		retrigger_enable = 1'b0;
		chan_timed = 2'h3;
		for (k = 0; k < 4; k++)
			go(3, 2, 0, 0, 0, 0, 1, k, k == 2 ? 7 : k == 1 ? 5 : 4, 0, 1, 0);
		go(6, 1, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1);
		test_done();
	end

	// runs take under 10000 cycles; five times that means a hang
	initial begin
		#1000000;
		num_errors++;
		test_done();
	end
endmodule
